// [common/adbat_if.sv]
`timescale 1ns/10ps
interface adbat_if;
  logic              extract_bus_clock;
  logic [7:0]        extract_bus_data;
  logic              extract_bus_parity;
  logic              insert_bus_clock;
  logic              insert_payload_envelope;
  logic              insert_frame_marker;
  logic              insert_bus_drive_enable;
  logic [7:0]        insert_bus_data;
  logic              insert_bus_data_oe;
  logic              insert_bus_parity;
  logic              insert_slot_active_out;
  logic              aux_out_clock;
  logic              aux_out_location_valid;
  logic [1:0]        aux_out_location;
  logic              aux_out_data_valid;
  logic [7:0]        aux_out_data;
  logic              aux_in_clock;
  logic              aux_in_location_valid;
  logic [1:0]        aux_in_location;
  logic              aux_in_data_valid;
  logic [7:0]        aux_in_data;
  modport dev (
    input  extract_bus_clock, extract_bus_data, extract_bus_parity,
    input  insert_bus_clock, insert_payload_envelope,
    input  insert_frame_marker, insert_bus_drive_enable, aux_in_data,
    output insert_bus_data, insert_bus_data_oe, insert_bus_parity,
    output insert_slot_active_out, aux_out_clock, aux_out_location_valid,
    output aux_out_location, aux_out_data_valid, aux_out_data,
    output aux_in_clock, aux_in_location_valid, aux_in_location,
    output aux_in_data_valid
  );
  modport far (
    output extract_bus_clock, extract_bus_data, extract_bus_parity,
    output insert_bus_clock, insert_payload_envelope,
    output insert_frame_marker, insert_bus_drive_enable, aux_in_data,
    input  insert_bus_data, insert_bus_data_oe, insert_bus_parity,
    input  insert_slot_active_out, aux_out_clock, aux_out_location_valid,
    input  aux_out_location, aux_out_data_valid, aux_out_data,
    input  aux_in_clock, aux_in_location_valid, aux_in_location,
    input  aux_in_data_valid
  );
endinterface

// [common/adbat_pkg.sv]
// Overview of operation
// - Extract inputs captured on rising, invert selects falling
// - Insert samples rising, launches falling; invert swaps
// - Gapped extract clock: skipped edges advance nothing
// - Gapped insert clock: skipped edges advance nothing
// - Extra delay: insert byte, parity, active one later
// - Extra delay: far side delays drive enable too
// - Far side V1 marker 3/6 cycles after J1
// - Slot active changes with insert data launch
// - Aux clocks toggle to twice bus clock period
// - Aux input transfers only with insert slot valid
// - Aux output transfers only with extract slot valid
// - Aux input byte fetched only if item enabled
// - Location valid low one aux period between transfers
// - Aux strobes change on aux clock falling edge
// - Aux input data sampled on aux clock rising edge
package adbat_pkg;
  localparam int DATA_W        = 8;
  localparam int FIFO_DEPTH    = 16;
  localparam int LOC_W         = 2;
  localparam int CLK_SYS_MHZ   = 40;
  localparam int BUS_HALF_NS   = 100;
  localparam int BUS_HALF_CYC  = (BUS_HALF_NS * CLK_SYS_MHZ) / 1000;
  localparam int V1_GAP_STS3   = 3;
  localparam int V1_GAP_STM1   = 6;
  localparam int FRAME_SLOTS   = 32;
  localparam int DRIVE_FIRST   = 8;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam int CTRL_DELAY_BIT   = 0;
  localparam int CTRL_STM1_BIT    = 1;
  localparam int CTRL_GAP_BIT     = 2;
  localparam int CTRL_EXT_INV_BIT = 4;
  localparam int CTRL_INS_INV_BIT = 5;
  localparam logic [31:0] CTRL_MASK  = 32'h00000037;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  typedef enum logic [1:0] {
    AUX_GAP = 2'b00,
    AUX_LOC = 2'b01,
    AUX_DAT = 2'b10
  } adbat_aux_e;
endpackage

// [logic/adbat_dev.sv]
`timescale 1ns/10ps
module adbat_fifo
  import adbat_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int D = FIFO_DEPTH
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;

  assign push        = in_valid_i & ~full;
  assign pop         = out_ready_i & ~empty;
  assign full        = ~in_ready_o;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Flags registered so the ready port comes from a flop
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      in_ready_o <= 1'b1;
      empty  <= 1'b1;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      in_ready_o <= (next_count != CW'(D));
      empty <= (next_count == '0);
    end
  end
endmodule

module adbat_dev
  import adbat_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  adbat_if.dev             bus,
  input  wire logic        extract_edge_invert_i,
  input  wire logic        insert_edge_invert_i,
  input  wire logic        insert_extra_delay_i,
  input  wire logic        extract_slot_valid_i,
  input  wire logic        insert_slot_valid_i,
  input  wire logic [3:0]  aux_enable_i,
  input  wire logic [7:0]  ins_data_i,
  input  wire logic        ins_valid_i,
  output logic             ins_ready_o,
  output logic [7:0]       ext_data_o,
  output logic             ext_parity_o,
  output logic             ext_valid_o,
  output logic [7:0]       aux_in_byte_o,
  output logic [1:0]       aux_in_loc_o,
  output logic             aux_in_byte_valid_o
);
  function automatic adbat_aux_e aux_next(adbat_aux_e st, logic ok,
                                          logic en);
    case (st)
      AUX_GAP: aux_next = ok ? AUX_LOC : AUX_GAP;
      AUX_LOC: aux_next = (ok && en) ? AUX_DAT : AUX_GAP;
      AUX_DAT: aux_next = AUX_GAP;
      default: aux_next = AUX_GAP;
    endcase
  endfunction

  logic [21:0] pin_s1;
  logic [21:0] pin_s2;
  logic        ext_clk_q;
  logic        ins_clk_q;
  logic        ext_rise;
  logic        ext_fall;
  logic        ins_rise;
  logic        ins_fall;
  logic        ext_cap;
  logic        ins_smp;
  logic        ins_lch;
  logic [7:0]  fifo_data;
  logic        fifo_valid;
  logic        fifo_ready;
  logic        fifo_in_ready;
  logic [7:0]  stage0;
  logic [7:0]  stage1;
  logic        act0;
  logic        act1;
  logic        den_q;
  logic        ao_fall;
  logic        ai_fall;
  logic        ai_rise;
  adbat_aux_e  ao_st;
  adbat_aux_e  ai_st;
  adbat_aux_e  next_ao_st;
  adbat_aux_e  next_ai_st;
  logic [1:0]  ao_loc;
  logic [1:0]  ai_loc;

  // Every pin passes two flops; only pin_s2 is read beyond them
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {bus.extract_bus_clock, bus.extract_bus_parity,
                 bus.extract_bus_data, bus.insert_bus_clock,
                 bus.insert_payload_envelope, bus.insert_frame_marker,
                 bus.insert_bus_drive_enable, bus.aux_in_data};
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext_clk_q <= 1'b0;
      ins_clk_q <= 1'b0;
    end else begin
      ext_clk_q <= pin_s2[21];
      ins_clk_q <= pin_s2[11];
    end
  end

  // A skipped edge pair simply yields no event
  assign ext_rise = pin_s2[21] & ~ext_clk_q;
  assign ext_fall = ~pin_s2[21] & ext_clk_q;
  assign ins_rise = pin_s2[11] & ~ins_clk_q;
  assign ins_fall = ~pin_s2[11] & ins_clk_q;
  assign ext_cap  = extract_edge_invert_i ? ext_fall : ext_rise;
  assign ins_smp  = insert_edge_invert_i ? ins_fall : ins_rise;
  assign ins_lch  = insert_edge_invert_i ? ins_rise : ins_fall;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext_data_o   <= 8'h00;
      ext_parity_o <= 1'b0;
      ext_valid_o  <= 1'b0;
    end else begin
      ext_valid_o <= ext_cap;
      if (ext_cap) begin
        ext_data_o   <= pin_s2[19:12];
        ext_parity_o <= pin_s2[20];
      end
    end
  end

  // Bus cannot stall, so an empty FIFO sends an idle slot
  assign fifo_ready  = ins_smp & pin_s2[10];
  assign ins_ready_o = fifo_in_ready;

  adbat_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_data_i   (ins_data_i),
    .in_valid_i  (ins_valid_i),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stage0 <= 8'h00;
      stage1 <= 8'h00;
      act0   <= 1'b0;
      act1   <= 1'b0;
      den_q  <= 1'b0;
    end else if (ins_smp) begin
      stage0 <= (pin_s2[10] && fifo_valid) ? fifo_data : 8'h00;
      act0   <= pin_s2[10] & fifo_valid;
      stage1 <= stage0;
      act1   <= act0;
      den_q  <= pin_s2[8];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus.insert_bus_data        <= 8'h00;
      bus.insert_bus_parity      <= 1'b0;
      bus.insert_slot_active_out <= 1'b0;
      bus.insert_bus_data_oe     <= 1'b0;
    end else if (ins_lch) begin
      bus.insert_bus_data <= insert_extra_delay_i ? stage1 : stage0;
      bus.insert_bus_parity <= insert_extra_delay_i ? ^stage1 : ^stage0;
      bus.insert_slot_active_out <= insert_extra_delay_i ? act1 :
                                    act0;
      // Far side already shifts drive enable when delayed
      bus.insert_bus_data_oe <= den_q;
    end
  end

  // Aux clocks toggle on each bus rising edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus.aux_out_clock <= 1'b0;
      bus.aux_in_clock  <= 1'b0;
    end else begin
      if (ext_rise) bus.aux_out_clock <= ~bus.aux_out_clock;
      if (ins_rise) bus.aux_in_clock <= ~bus.aux_in_clock;
    end
  end

  assign ao_fall    = ext_rise & bus.aux_out_clock;
  assign ai_fall    = ins_rise & bus.aux_in_clock;
  assign ai_rise    = ins_rise & ~bus.aux_in_clock;
  assign next_ao_st = aux_next(ao_st, extract_slot_valid_i, 1'b1);
  assign next_ai_st = aux_next(ai_st, insert_slot_valid_i,
                               aux_enable_i[~ai_loc]);

  // GAP state lasts one aux period with location valid low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ao_st                      <= AUX_GAP;
      ao_loc                     <= 2'h0;
      bus.aux_out_location_valid <= 1'b0;
      bus.aux_out_location       <= 2'h0;
      bus.aux_out_data_valid     <= 1'b0;
      bus.aux_out_data           <= 8'h00;
    end else if (ao_fall) begin
      ao_st <= next_ao_st;
      if (ao_st != AUX_GAP && next_ao_st == AUX_GAP) ao_loc <= ao_loc + 1'b1;
      bus.aux_out_location_valid <= (next_ao_st != AUX_GAP);
      bus.aux_out_location       <= ao_loc;
      bus.aux_out_data_valid     <= (next_ao_st == AUX_DAT);
      bus.aux_out_data           <= ext_data_o;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ai_st                     <= AUX_GAP;
      ai_loc                    <= 2'h0;
      bus.aux_in_location_valid <= 1'b0;
      bus.aux_in_location       <= 2'h0;
      bus.aux_in_data_valid     <= 1'b0;
    end else if (ai_fall) begin
      ai_st <= next_ai_st;
      if (ai_st != AUX_GAP && next_ai_st == AUX_GAP) ai_loc <= ai_loc + 1'b1;
      bus.aux_in_location_valid <= (next_ai_st != AUX_GAP);
      bus.aux_in_location       <= ai_loc;
      bus.aux_in_data_valid     <= (next_ai_st == AUX_DAT);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aux_in_byte_o       <= 8'h00;
      aux_in_loc_o        <= 2'h0;
      aux_in_byte_valid_o <= 1'b0;
    end else begin
      aux_in_byte_valid_o <= ai_rise & (ai_st == AUX_DAT);
      if (ai_rise && ai_st == AUX_DAT) begin
        aux_in_byte_o <= pin_s2[7:0];
        aux_in_loc_o  <= ai_loc;
      end
    end
  end
endmodule

// [logic/adbat_far.sv]
`timescale 1ns/10ps
module adbat_far
  import adbat_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  adbat_if.far             bus,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  ext_byte_i,
  input  wire logic        gap_req_i,
  input  wire logic [7:0]  aux_in_byte_i,
  output logic [7:0]       ins_byte_o,
  output logic             ins_byte_valid_o,
  output logic [7:0]       aux_out_byte_o,
  output logic [1:0]       aux_out_loc_o,
  output logic             aux_out_valid_o
);
  localparam int DW = $clog2(BUS_HALF_CYC);
  localparam int SLW = $clog2(FRAME_SLOTS);
  logic [31:0]    ctrl;
  logic [DW-1:0]  div_cnt;
  logic           half_tick;
  logic           ph;
  logic           skip;
  logic           gap_now;
  logic           rise_ev;
  logic           fall_ev;
  logic           ext_lch;
  logic           ins_lch;
  logic [SLW-1:0] slot;
  logic [SLW-1:0] v1_slot;
  logic           den_prev;
  logic [21:0]    pin_s1;
  logic [21:0]    pin_s2;
  logic           ao_clk_q;
  logic           ai_clk_q;

  // One wait cycle: request taken when waitrequest is low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
      ctrl              <= CTRL_RESET;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL) begin
        ctrl <= avs_writedata_i & CTRL_MASK;
      end
      if (avs_read_i && avs_waitrequest_o) begin
        case (avs_address_i)
          REG_CTRL:   avs_readdata_o <= ctrl;
          REG_STATUS: avs_readdata_o <= {14'h0000, aux_out_loc_o,
                                         aux_out_byte_o, ins_byte_o};
          default:    avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  assign half_tick = (div_cnt == DW'(BUS_HALF_CYC - 1));
  assign gap_now   = ctrl[CTRL_GAP_BIT] & gap_req_i;
  assign rise_ev   = half_tick & ~ph & ~gap_now;
  assign fall_ev   = half_tick & ph & ~skip;
  assign ext_lch   = ctrl[CTRL_EXT_INV_BIT] ? rise_ev : fall_ev;
  assign ins_lch   = ctrl[CTRL_INS_INV_BIT] ? rise_ev : fall_ev;

  // A gap drops one rise and the fall after it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_cnt               <= '0;
      ph                    <= 1'b0;
      skip                  <= 1'b0;
      bus.extract_bus_clock <= 1'b0;
      bus.insert_bus_clock  <= 1'b0;
    end else begin
      div_cnt <= half_tick ? '0 : div_cnt + 1'b1;
      if (half_tick) begin
        ph <= ~ph;
        if (!ph) skip <= gap_now;
        bus.extract_bus_clock <= ~ph & ~gap_now;
        bus.insert_bus_clock  <= ~ph & ~gap_now;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus.extract_bus_data   <= 8'h00;
      bus.extract_bus_parity <= 1'b0;
    end else if (ext_lch) begin
      bus.extract_bus_data   <= ext_byte_i;
      bus.extract_bus_parity <= ^ext_byte_i;
    end
  end

  assign v1_slot = ctrl[CTRL_STM1_BIT] ? SLW'(V1_GAP_STM1) : SLW'(V1_GAP_STS3);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      slot                        <= '0;
      den_prev                    <= 1'b0;
      bus.insert_payload_envelope <= 1'b0;
      bus.insert_frame_marker     <= 1'b0;
      bus.insert_bus_drive_enable <= 1'b0;
    end else if (ins_lch) begin
      slot <= (slot == SLW'(FRAME_SLOTS - 1)) ? '0 : slot + 1'b1;
      bus.insert_payload_envelope <= (slot != '0);
      bus.insert_frame_marker <= (slot == '0) || (slot == v1_slot);
      den_prev <= (slot >= SLW'(DRIVE_FIRST));
      bus.insert_bus_drive_enable <= ctrl[CTRL_DELAY_BIT] ? den_prev :
                                     (slot >= SLW'(DRIVE_FIRST));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {bus.insert_bus_data, bus.insert_slot_active_out,
                 bus.aux_out_clock, bus.aux_out_data_valid,
                 bus.aux_out_location, bus.aux_in_clock, bus.aux_out_data};
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ao_clk_q <= 1'b0;
      ai_clk_q <= 1'b0;
    end else begin
      ao_clk_q <= pin_s2[12];
      ai_clk_q <= pin_s2[8];
    end
  end

  // Previous slot's byte is settled by the next launch edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ins_byte_o       <= 8'h00;
      ins_byte_valid_o <= 1'b0;
    end else begin
      ins_byte_valid_o <= ins_lch & pin_s2[13];
      if (ins_lch && pin_s2[13]) ins_byte_o <= pin_s2[21:14];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aux_out_byte_o  <= 8'h00;
      aux_out_loc_o   <= 2'h0;
      aux_out_valid_o <= 1'b0;
      bus.aux_in_data <= 8'h00;
    end else begin
      aux_out_valid_o <= pin_s2[12] & ~ao_clk_q & pin_s2[11];
      if (pin_s2[12] && !ao_clk_q && pin_s2[11]) begin
        aux_out_byte_o <= pin_s2[7:0];
        aux_out_loc_o  <= pin_s2[10:9];
      end
      if (!pin_s2[8] && ai_clk_q) bus.aux_in_data <= aux_in_byte_i;
    end
  end
endmodule

// [tb/adbat_chk.sv]
`timescale 1ns/10ps
module adbat_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic extract_bus_clock,
  input wire logic insert_bus_clock,
  input wire logic aux_out_clock,
  input wire logic aux_out_location_valid,
  input wire logic aux_out_data_valid,
  input wire logic aux_in_clock,
  input wire logic aux_in_location_valid,
  input wire logic aux_in_data_valid
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Pin sync costs a few cycles, so the window is six
  chk_out_clk_follow : assert property (
    $rose(extract_bus_clock) |-> ##[1:6] $changed(aux_out_clock))
    else $error("aux out clock missed a bus rise");
  chk_in_clk_follow : assert property (
    $rose(insert_bus_clock) |-> ##[1:6] $changed(aux_in_clock))
    else $error("aux in clock missed a bus rise");
  // A skipped edge may stretch a phase, never shorten it
  chk_out_clk_phase : assert property (
    $changed(aux_out_clock) |=> $stable(aux_out_clock)[*7])
    else $error("aux out clock phase too short");
  chk_in_clk_phase : assert property (
    $changed(aux_in_clock) |=> $stable(aux_in_clock)[*7])
    else $error("aux in clock phase too short");
  chk_out_strobe_edge : assert property (
    ($changed(aux_out_location_valid) || $changed(aux_out_data_valid))
    |-> !aux_out_clock)
    else $error("aux out strobe moved off the falling edge");
  chk_in_strobe_edge : assert property (
    ($changed(aux_in_location_valid) || $changed(aux_in_data_valid))
    |-> !aux_in_clock)
    else $error("aux in strobe moved off the falling edge");
  chk_out_valid_gap : assert property (
    $fell(aux_out_location_valid)
    |=> !aux_out_location_valid[*8] ##1 !aux_out_location_valid[*7])
    else $error("aux out location valid gap too short");
  chk_in_valid_gap : assert property (
    $fell(aux_in_location_valid)
    |=> !aux_in_location_valid[*8] ##1 !aux_in_location_valid[*7])
    else $error("aux in location valid gap too short");
  chk_out_no_partial : assert property (
    aux_out_data_valid |-> aux_out_location_valid)
    else $error("aux out data valid without location valid");
  cover property (aux_out_data_valid);
  cover property (aux_in_data_valid);
  cover property ($fell(aux_in_location_valid));
endmodule

// [tb/test_add_drop_bus_aux_port_timing.sv]
`timescale 1ns/10ps
`define check_eq(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_total++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); \
  end end
module test_add_drop_bus_aux_port_timing
  import adbat_pkg::*;
;
  logic        clk_sys_i, rst_i, extract_edge_invert_i, insert_edge_invert_i;
  logic        insert_extra_delay_i, extract_slot_valid_i, insert_slot_valid_i;
  logic        ins_valid_i, ins_ready_o, ext_parity_o, ext_valid_o;
  logic        aux_in_byte_valid_o, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        gap_req_i, ins_byte_valid_o, aux_out_valid_o, ic, prev_ic;
  logic        have_o, ok, off, stm;
  logic [1:0]  aux_in_loc_o, aux_out_loc_o, prev_oloc;
  logic [3:0]  aux_enable_i, avs_address_i;
  logic [7:0]  ins_data_i, ext_data_o, aux_in_byte_o, ext_byte_i;
  logic [7:0]  aux_in_byte_i, ins_byte_o, aux_out_byte_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [7:0]  q[$];
  int          err_total, samples_checked, rc, n, full;
  adbat_if     bus();
  adbat_dev u_adbat_dev (.*);
  adbat_far u_adbat_far (.*);
  adbat_chk u_adbat_chk (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .extract_bus_clock(bus.extract_bus_clock),
    .insert_bus_clock(bus.insert_bus_clock),
    .aux_out_clock(bus.aux_out_clock),
    .aux_out_location_valid(bus.aux_out_location_valid),
    .aux_out_data_valid(bus.aux_out_data_valid),
    .aux_in_clock(bus.aux_in_clock),
    .aux_in_location_valid(bus.aux_in_location_valid),
    .aux_in_data_valid(bus.aux_in_data_valid)
  );
  assign ic = bus.insert_bus_clock;
  always #12.5 clk_sys_i = ~clk_sys_i;
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Held until waitrequest is sampled low; a hang is left to the watchdog
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic push(input int cnt);
    @(posedge clk_sys_i);
    for (int i = 0; i < cnt; i++) begin
      ins_valid_i <= 1'b1;
      ins_data_i <= 8'($urandom);
      @(posedge clk_sys_i);
      while (ins_ready_o !== 1'b1) begin
        full++;
        @(posedge clk_sys_i);
      end
      q.push_back(ins_data_i);
    end
    ins_valid_i <= 1'b0;
  endtask
  always @(posedge clk_sys_i) begin
    gap_req_i <= 1'($urandom);
    prev_ic <= ic;
    if (rst_i) begin
      rc <= 99;
      have_o <= 1'b0;
    end else begin
      // Bytes lost before drive enable are skipped, order must hold
      if (ins_byte_valid_o) begin
        while (q.size() > 0 && q[0] !== ins_byte_o) void'(q.pop_front());
        `check_eq(q.size() > 0, 1'b1)
        if (q.size() > 0) void'(q.pop_front());
      end
      if (ext_valid_o && ok) begin
        `check_eq(ext_data_o, ext_byte_i)
        `check_eq(ext_parity_o, ^ext_byte_i)
      end
      if (aux_in_byte_valid_o) begin
        `check_eq(aux_enable_i[3 - aux_in_loc_o], 1'b1)
        `check_eq(off, 1'b0)
        if (ok) `check_eq(aux_in_byte_o, aux_in_byte_i)
      end
      if (aux_out_valid_o) begin
        `check_eq(off, 1'b0)
        if (have_o) `check_eq(aux_out_loc_o, prev_oloc + 2'd1)
        have_o <= 1'b1;
        prev_oloc <= aux_out_loc_o;
      end
      if (insert_edge_invert_i ? prev_ic && !ic : !prev_ic && ic) begin
        if (bus.insert_frame_marker) begin
          if (rc < 16 && ok)
            `check_eq(rc, stm ? V1_GAP_STM1 : V1_GAP_STS3)
          rc <= 1;
        end else
          rc <= rc + 1;
      end
    end
  end
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    err_total++;
    end_of_test;
  end
  initial begin
    {clk_sys_i, rst_i, ins_valid_i, avs_read_i, avs_write_i} = 5'b01000;
    {extract_edge_invert_i, insert_edge_invert_i, insert_extra_delay_i} = 0;
    {extract_slot_valid_i, insert_slot_valid_i, gap_req_i, ok, off} = 0;
    {aux_enable_i, avs_address_i, ins_data_i, ext_byte_i} = 0;
    {aux_in_byte_i, avs_writedata_i, stm} = 0;
    n = $urandom(19);
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    av(1'b0, REG_CTRL, 32'h0, rd);
    `check_eq(rd, CTRL_RESET)
    av(1'b1, REG_CTRL, 32'hFFFFFFFF, rd);
    av(1'b1, REG_STATUS, 32'hFFFFFFFF, rd);
    av(1'b1, 4'hC, 32'hFFFFFFFF, rd);
    av(1'b0, REG_CTRL, 32'h0, rd);
    `check_eq(rd, CTRL_MASK)
    av(1'b0, 4'hC, 32'h0, rd);
    `check_eq(rd, 32'h0)
    for (int cfg = 0; cfg < 8; cfg++) begin
      ok <= 1'b0;
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      {insert_edge_invert_i, extract_edge_invert_i} <= 2'(cfg >> 1);
      insert_extra_delay_i <= cfg[0];
      stm <= 1'($urandom);
      ext_byte_i <= 8'($urandom);
      aux_in_byte_i <= 8'($urandom);
      aux_enable_i <= 4'(cfg * 5 + 3);
      {extract_slot_valid_i, insert_slot_valid_i} <= 2'b11;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      av(1'b1, REG_CTRL, {26'h0, insert_edge_invert_i, extract_edge_invert_i,
         1'b0, 1'($urandom), stm, insert_extra_delay_i}, rd);
      // Far end retimes its frame on the write; let one frame pass
      repeat (300) @(posedge clk_sys_i);
      ok <= 1'b1;
      full = 0;
      push(40);
      `check_eq(full > 0, 1'b1)
      for (n = 0; n < 3000 && q.size() > 0; n++) @(posedge clk_sys_i);
      `check_eq(q.size(), 0)
      {extract_slot_valid_i, insert_slot_valid_i} <= 2'b00;
      repeat (96) @(posedge clk_sys_i);
      off <= 1'b1;
      repeat (300) @(posedge clk_sys_i);
      off <= 1'b0;
    end
    end_of_test;
  end
endmodule
